// file: rtl/uprc_pkg.sv
// Constants and types of the USB port routing and port control registers.
// How it works
// [RULE_01] Software sets configure flag bit 0 only as its last setup step.
// [RULE_02] Configure flag 0 routes each port to a companion controller.
// [RULE_03] Configure flag 1 routes every port to this controller; the code sends a port whose owner bit is set back to the companion.
// [RULE_04] Port registers sit in the aux well, reset at power-up or reset.
// [RULE_05] After that reset each port shows no device and is disabled.
// [RULE_06] With power switching, port state is frozen until power is set.
// [RULE_07] Software waits up to 20 ms for port power to settle first.
// [RULE_08] Port bit 22, reset 0, makes overcurrent a wake-up event.
// [RULE_09] Port bit 21, reset 0, makes device detach a wake-up event.
// [RULE_10] Port bit 20, reset 0, makes device attach a wake-up event.
// [RULE_11] Software writes reserved bits with zero.
// [RULE_12] Port registers sit at 64h plus four bytes per further port.
// [RULE_13] Owner bit 13 clears on a flag rise and is 1 while the flag is 0.
// [RULE_14] A wake request comes only from an enabled event while suspended.
// [RULE_15] Writes to read-only port fields are ignored.
package uprc_pkg;

    localparam int UPRC_NUM_PORTS = 2;

    // Register byte offsets
    localparam logic [7:0] UPRC_OFS_ROUTE = 8'h60;
    localparam logic [7:0] UPRC_OFS_PORT1 = 8'h64;
    localparam logic [7:0] UPRC_PORT_STRIDE = 8'h04;
    localparam logic [7:0] UPRC_OFS_IRQ_STAT = 8'h70;
    localparam logic [7:0] UPRC_OFS_IRQ_MASK = 8'h74;

    // Routing register field
    localparam int UPRC_CF_BIT = 0;

    // Port register field positions
    localparam int UPRC_P_CONN = 0;
    localparam int UPRC_P_CONN_CHG = 1;
    localparam int UPRC_P_EN = 2;
    localparam int UPRC_P_EN_CHG = 3;
    localparam int UPRC_P_OC_NOW = 4;
    localparam int UPRC_P_OC_CHG = 5;
    localparam int UPRC_P_RESUME = 6;
    localparam int UPRC_P_SLEEP = 7;
    localparam int UPRC_P_BUS_RST = 8;
    localparam int UPRC_P_LSTATE = 10;
    localparam int UPRC_P_POWER = 12;
    localparam int UPRC_P_OWNER = 13;
    localparam int UPRC_P_TEST = 16;
    localparam int UPRC_P_WAKE_ATT = 20;
    localparam int UPRC_P_WAKE_DET = 21;
    localparam int UPRC_P_WAKE_OC = 22;

    // Interrupt status / mask layout
    localparam int UPRC_I_CONN = 0;
    localparam int UPRC_I_OC = 2;
    localparam int UPRC_I_EN = 4;
    localparam int UPRC_I_WAKE = 6;
    localparam int UPRC_IRQ_W = 7;

    // Reset values
    localparam logic [31:0] UPRC_PORT_RESET = 32'h0000_2000;
    localparam logic [31:0] UPRC_ROUTE_RESET = 32'h0000_0000;
    localparam logic [UPRC_IRQ_W-1:0] UPRC_IRQ_RESET = 7'h00;
    localparam logic UPRC_POWER_SWITCHED = 1'b1;

    // Bus reset driven on a new attach
    localparam int UPRC_MCLK_MHZ = 10;
    localparam int UPRC_BUS_RESET_US = 10;
    localparam int UPRC_BUS_RESET_CYCLES = UPRC_BUS_RESET_US * UPRC_MCLK_MHZ;
    localparam int UPRC_RST_CNT_W = 7;

    typedef enum logic [1:0] {
        UPRC_LINK_IDLE = 2'b00,
        UPRC_LINK_RESET = 2'b01,
        UPRC_LINK_ACTIVE = 2'b11
    } uprc_link_e;

    typedef struct packed {
        uprc_link_e link;
        logic [UPRC_RST_CNT_W-1:0] rst_cnt;
        logic wake_oc;
        logic wake_det;
        logic wake_att;
        logic [3:0] test_sel;
        logic owner;
        logic power;
        logic [1:0] lstate;
        logic bus_rst;
        logic sleep;
        logic resume;
        logic oc_chg;
        logic oc_now;
        logic en_chg;
        logic en;
        logic conn_chg;
        logic conn;
    } uprc_port_s;

endpackage

// file: rtl/uprc_sync3.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module uprc_sync3
    import uprc_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] level;
    } uprc_sync_s;

    uprc_sync_s s_q;
    uprc_sync_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.ff1 = pin_in;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        // Accept a change only once stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (s_q.ff2[i] == s_q.ff3[i]) begin
                s_d.level[i] = s_q.ff3[i];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.level;

endmodule
`default_nettype wire

// file: rtl/uprc_top.sv
// Port routing flag, two port status/control registers and interrupts.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module uprc_top
    import uprc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [UPRC_NUM_PORTS-1:0] attach_pin,
    input wire logic [UPRC_NUM_PORTS-1:0] overcurrent_pin,
    input wire logic ctrl_suspended,
    output logic [UPRC_NUM_PORTS-1:0] companion_route,
    output logic [UPRC_NUM_PORTS-1:0] port_power_on,
    output logic [UPRC_NUM_PORTS-1:0] port_bus_reset,
    output logic [UPRC_NUM_PORTS-1:0] port_enabled,
    output logic wake_req,
    output logic irq
);

    typedef struct packed {
        logic cf;
        uprc_port_s [UPRC_NUM_PORTS-1:0] port;
        logic [UPRC_IRQ_W-1:0] stat;
        logic [UPRC_IRQ_W-1:0] mask;
        logic [31:0] rdata;
        logic wake;
        logic irq;
        logic [UPRC_NUM_PORTS-1:0] route;
        logic [UPRC_NUM_PORTS-1:0] pwr;
        logic [UPRC_NUM_PORTS-1:0] brst;
        logic [UPRC_NUM_PORTS-1:0] en;
    } uprc_state_s;

    uprc_state_s s_q;
    uprc_state_s s_d;

    logic [UPRC_NUM_PORTS-1:0] attach_lvl;
    logic [UPRC_NUM_PORTS-1:0] oc_lvl;

    // Attach and overcurrent pins come from outside the clock domain
    uprc_sync3 #(
        .W(2 * UPRC_NUM_PORTS)
    ) u_pin_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in({overcurrent_pin, attach_pin}),
        .level_out({oc_lvl, attach_lvl})
    );

    // Port n (0-based) at 64h plus four bytes per port
    function automatic logic port_hit(
        input logic [7:0] addr,
        input int n
    );
        logic [7:0] base;
        base = UPRC_OFS_PORT1 + 8'(n) * UPRC_PORT_STRIDE; // [RULE_12]
        return addr == base;
    endfunction

    function automatic logic [31:0] port_word(input uprc_port_s p);
        logic [31:0] w;
        w = '0;
        w[UPRC_P_CONN] = p.conn;
        w[UPRC_P_CONN_CHG] = p.conn_chg;
        w[UPRC_P_EN] = p.en;
        w[UPRC_P_EN_CHG] = p.en_chg;
        w[UPRC_P_OC_NOW] = p.oc_now;
        w[UPRC_P_OC_CHG] = p.oc_chg;
        w[UPRC_P_RESUME] = p.resume;
        w[UPRC_P_SLEEP] = p.sleep;
        w[UPRC_P_BUS_RST] = p.bus_rst;
        w[UPRC_P_LSTATE +: 2] = p.lstate;
        w[UPRC_P_POWER] = p.power;
        w[UPRC_P_OWNER] = p.owner;
        w[UPRC_P_TEST +: 4] = p.test_sel;
        w[UPRC_P_WAKE_ATT] = p.wake_att;
        w[UPRC_P_WAKE_DET] = p.wake_det;
        w[UPRC_P_WAKE_OC] = p.wake_oc;
        return w;
    endfunction

    function automatic uprc_port_s port_reset_val();
        uprc_port_s p;
        p = '0;
        p.link = UPRC_LINK_IDLE;
        p.owner = UPRC_PORT_RESET[UPRC_P_OWNER];
        return p;
    endfunction

    // Reset image of one port: no device, disabled, companion-owned
    localparam uprc_port_s UPRC_PORT_IDLE = port_reset_val();

    always_comb begin
        uprc_port_s p;
        logic cf_rise;
        logic wr_hit;
        logic rd_hit;
        logic conn_now;
        logic [UPRC_IRQ_W-1:0] ev;
        logic wake_ev;
        p = '0;
        cf_rise = 1'b0;
        wr_hit = 1'b0;
        rd_hit = 1'b0;
        conn_now = 1'b0;
        ev = '0;
        wake_ev = 1'b0;
        s_d = s_q;
        s_d.rdata = '0;

        // Routing register; reserved bits are not stored
        if (reg_wr && reg_addr == UPRC_OFS_ROUTE) begin
            s_d.cf = reg_wdata[UPRC_CF_BIT];
        end
        cf_rise = s_d.cf && !s_q.cf;

        for (int i = 0; i < UPRC_NUM_PORTS; i++) begin
            p = s_q.port[i];
            wr_hit = reg_wr && port_hit(reg_addr, i);
            rd_hit = reg_rd && port_hit(reg_addr, i);

            if (rd_hit) begin
                s_d.rdata = port_word(p);
                // Overcurrent change is read-only; reading retires it
                p.oc_chg = 1'b0;
            end

            // Connect, overcurrent-now, overcurrent-change and bus-reset
            // status bits are never taken from write data
            if (wr_hit) begin // [RULE_15]
                if (UPRC_POWER_SWITCHED) begin
                    p.power = reg_wdata[UPRC_P_POWER];
                end
                // Port state is frozen until power is on
                if (s_q.port[i].power ||
                    !UPRC_POWER_SWITCHED) begin // [RULE_06]
                    if (reg_wdata[UPRC_P_CONN_CHG]) begin
                        p.conn_chg = 1'b0;
                    end
                    if (reg_wdata[UPRC_P_EN_CHG]) begin
                        p.en_chg = 1'b0;
                    end
                    // Software may only disable; enable comes from a reset
                    if (!reg_wdata[UPRC_P_EN]) begin
                        p.en = 1'b0;
                    end
                    p.resume = reg_wdata[UPRC_P_RESUME];
                    p.sleep = reg_wdata[UPRC_P_SLEEP] && p.en;
                    p.lstate = reg_wdata[UPRC_P_LSTATE +: 2];
                    p.test_sel = reg_wdata[UPRC_P_TEST +: 4];
                    p.wake_oc = reg_wdata[UPRC_P_WAKE_OC]; // [RULE_08]
                    p.wake_det = reg_wdata[UPRC_P_WAKE_DET]; // [RULE_09]
                    p.wake_att = reg_wdata[UPRC_P_WAKE_ATT]; // [RULE_10]
                    if (s_q.cf) begin
                        p.owner = reg_wdata[UPRC_P_OWNER];
                    end
                end
            end

            // Power switches open on overcurrent before attach is seen,
            // so a dead port never starts a bus reset
            if (oc_lvl[i] && UPRC_POWER_SWITCHED) begin
                p.power = 1'b0;
            end

            // Connection tracking; an unpowered port reports nothing
            conn_now = attach_lvl[i] && p.power;
            if (conn_now != s_q.port[i].conn) begin
                p.conn = conn_now;
                p.conn_chg = 1'b1;
                ev[UPRC_I_CONN + i] = 1'b1;
                if (conn_now && p.wake_att) begin
                    wake_ev = 1'b1; // [RULE_10]
                end
                if (!conn_now && p.wake_det) begin
                    wake_ev = 1'b1; // [RULE_09]
                end
            end

            case (p.link)
                UPRC_LINK_IDLE: begin
                    if (conn_now && !s_q.port[i].conn) begin
                        p.link = UPRC_LINK_RESET;
                        p.bus_rst = 1'b1;
                        p.rst_cnt = '0;
                    end
                end
                UPRC_LINK_RESET: begin
                    if (!conn_now) begin
                        p.link = UPRC_LINK_IDLE;
                        p.bus_rst = 1'b0;
                    end else if (p.rst_cnt ==
                        UPRC_RST_CNT_W'(UPRC_BUS_RESET_CYCLES - 1)) begin
                        p.link = UPRC_LINK_ACTIVE;
                        p.bus_rst = 1'b0;
                        p.en = 1'b1;
                        p.en_chg = 1'b1;
                        ev[UPRC_I_EN + i] = 1'b1;
                    end else begin
                        p.rst_cnt = p.rst_cnt + 1'b1;
                    end
                end
                UPRC_LINK_ACTIVE: begin
                    if (!conn_now) begin
                        p.link = UPRC_LINK_IDLE;
                    end
                end
                default: begin
                    p.link = UPRC_LINK_IDLE;
                    p.bus_rst = 1'b0;
                end
            endcase

            // Losing the device or power drops the enable
            if (!conn_now && s_q.port[i].en) begin
                p.en = 1'b0;
                p.en_chg = 1'b1;
                ev[UPRC_I_EN + i] = 1'b1;
            end
            if (!p.en) begin
                p.sleep = 1'b0;
            end

            // Overcurrent; hardware set wins over read retire
            if (oc_lvl[i] != s_q.port[i].oc_now) begin
                p.oc_now = oc_lvl[i];
                p.oc_chg = 1'b1;
                ev[UPRC_I_OC + i] = 1'b1;
                if (p.wake_oc) begin
                    wake_ev = 1'b1; // [RULE_08]
                end
            end
            // Ownership follows the configure flag
            if (!s_d.cf) begin
                p.owner = 1'b1; // [RULE_13]
            end else if (cf_rise) begin
                p.owner = 1'b0; // [RULE_13]
            end

            s_d.port[i] = p;
            // Flag 0 sends every port to the companion, 1 keeps those whose owner bit is clear
            s_d.route[i] = !s_d.cf || p.owner; // [RULE_02] [RULE_03]
            s_d.pwr[i] = p.power;
            s_d.brst[i] = p.bus_rst;
            s_d.en[i] = p.en;
        end

        // Wake only matters while the controller sleeps
        if (!ctrl_suspended) begin
            s_d.wake = 1'b0;
        end else if (wake_ev) begin
            s_d.wake = 1'b1; // [RULE_14]
            ev[UPRC_I_WAKE] = 1'b1;
        end

        // Routing read-back and interrupt registers
        if (reg_rd && reg_addr == UPRC_OFS_ROUTE) begin
            s_d.rdata = 32'(s_q.cf);
        end else if (reg_rd && reg_addr == UPRC_OFS_IRQ_STAT) begin
            s_d.rdata = 32'(s_q.stat);
            s_d.stat = '0;
        end else if (reg_rd && reg_addr == UPRC_OFS_IRQ_MASK) begin
            s_d.rdata = 32'(s_q.mask);
        end
        if (reg_wr && reg_addr == UPRC_OFS_IRQ_MASK) begin
            s_d.mask = reg_wdata[UPRC_IRQ_W-1:0];
        end
        // New events survive a clearing read in the same cycle
        s_d.stat = s_d.stat | ev;
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    // Single reset stands for aux power-up and controller reset alike
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q.cf <= UPRC_ROUTE_RESET[UPRC_CF_BIT];
            for (int i = 0; i < UPRC_NUM_PORTS; i++) begin
                s_q.port[i] <= UPRC_PORT_IDLE; // [RULE_04] [RULE_05]
            end
            s_q.stat <= UPRC_IRQ_RESET;
            s_q.mask <= UPRC_IRQ_RESET;
            s_q.rdata <= '0;
            s_q.wake <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.route <= '1;
            s_q.pwr <= '0;
            s_q.brst <= '0;
            s_q.en <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign companion_route = s_q.route;
    assign port_power_on = s_q.pwr;
    assign port_bus_reset = s_q.brst;
    assign port_enabled = s_q.en;
    assign wake_req = s_q.wake;
    assign irq = s_q.irq;

endmodule
`default_nettype wire

// file: dv/uprc_device_model.sv
// Behavioural USB devices hanging on the two downstream ports.
`timescale 1ns/100ps
`default_nettype none
module uprc_device_model
    import uprc_pkg::*;
(
    input wire logic [UPRC_NUM_PORTS-1:0] plug,
    input wire logic [UPRC_NUM_PORTS-1:0] fault,
    output logic [UPRC_NUM_PORTS-1:0] attach_pin,
    output logic [UPRC_NUM_PORTS-1:0] overcurrent_pin
);
    initial begin
        attach_pin = '0;
        overcurrent_pin = '0;
    end
    for (genvar i = 0; i < UPRC_NUM_PORTS; i++) begin : g_dev
        // One-cycle bounce pulses that the pin filter must reject
        always @(plug[i]) begin
            attach_pin[i] = plug[i];
            #130 attach_pin[i] = !plug[i];
            #100 attach_pin[i] = plug[i];
        end
        // Pins move off the clock grid
        always @(fault[i]) begin
            overcurrent_pin[i] = #17 fault[i];
        end
    end
endmodule
`default_nettype wire

// file: dv/uprc_top_properties.sv
// Concurrent checks on the routing and port register block.
`timescale 1ns/100ps
`default_nettype none
module uprc_top_properties
    import uprc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [UPRC_NUM_PORTS-1:0] overcurrent_pin,
    input wire logic ctrl_suspended,
    input wire logic [UPRC_NUM_PORTS-1:0] companion_route,
    input wire logic [UPRC_NUM_PORTS-1:0] port_power_on,
    input wire logic [UPRC_NUM_PORTS-1:0] port_bus_reset,
    input wire logic [UPRC_NUM_PORTS-1:0] port_enabled,
    input wire logic wake_req
);
    logic cf_q;
    logic wr_route;
    logic wr_port1;
    assign wr_route = reg_wr && reg_addr == UPRC_OFS_ROUTE;
    assign wr_port1 = reg_wr && reg_addr == UPRC_OFS_PORT1;
    // Shadow of the configure flag, seen only through the bus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cf_q <= 1'b0;
        end else if (wr_route) begin
            cf_q <= reg_wdata[UPRC_CF_BIT];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence cf_rise_s;
        wr_route && reg_wdata[UPRC_CF_BIT] && !cf_q;
    endsequence
    sequence reset_hold_s;
        (port_bus_reset[0] && !port_enabled[0]) throughout (##99 1'b1);
    endsequence
    unmapped_read_a: assert property (reg_rd && !(reg_addr inside
        {8'h60, 8'h64, 8'h68, 8'h70, 8'h74}) |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    route_companion_a: assert property (!cf_q && !$past(cf_q)
        |-> companion_route == 2'b11)
        else $error("ports not with companion while flag clear");
    route_own_a: assert property (cf_rise_s
        |=> ##[0:1] companion_route == 2'b00)
        else $error("ports not taken over on flag rise");
    power_write_a: assert property (wr_port1
        && !overcurrent_pin[0]
        |=> port_power_on[0] == $past(reg_wdata[UPRC_P_POWER]))
        else $error("power switch not following write");
    reset_power_a: assert property ($rose(port_bus_reset[0])
        |-> port_power_on[0])
        else $error("bus reset on unpowered port");
    reset_length_a: assert property ($rose(port_bus_reset[0])
        |-> reset_hold_s ##1 !port_bus_reset[0])
        else $error("bus reset length wrong");
    wake_idle_a: assert property (!ctrl_suspended |=> !wake_req)
        else $error("wake request while awake");
    wake_cause_a: assert property ($rose(wake_req)
        |-> $past(ctrl_suspended))
        else $error("wake request without suspend");
endmodule
bind uprc_top uprc_top_properties chk (.mclk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .overcurrent_pin,
    .ctrl_suspended, .companion_route, .port_power_on, .port_bus_reset,
    .port_enabled, .wake_req);
`default_nettype wire

// file: dv/usb_port_routing_control_bench.sv
// Self-checking bench for the routing and port register block.
`timescale 1ns/100ps
`default_nettype none
module usb_port_routing_control_bench
    import uprc_pkg::*;
;
    localparam logic [31:0] M = 32'hFFFF_F3FF;
    localparam logic [31:0] F = 32'hFFFF_FFFF;
    logic mclk, rst, reg_wr, reg_rd, ctrl_suspended, wake_req, irq, rd_d;
    logic [7:0] reg_addr, pa;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [63:0] e;
    logic [63:0] exp_q[$];
    logic [1:0] attach_pin, overcurrent_pin, companion_route, plug, fault;
    logic [1:0] port_power_on, port_bus_reset, port_enabled;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    uprc_top dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .attach_pin, .overcurrent_pin, .ctrl_suspended,
        .companion_route, .port_power_on, .port_bus_reset, .port_enabled,
        .wake_req, .irq);
    uprc_device_model devs (.plug, .fault, .attach_pin, .overcurrent_pin);
    always #50 mclk = !mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back({m, x & m});
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    // Settle on the low phase so registered outputs have landed
    task automatic low(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic await_en(input int p);
        for (int n = 0; n < 400 && port_enabled[p] !== 1'b1; n++) begin
            @(negedge mclk);
        end
    endtask
    always @(posedge mclk) rd_d <= reg_rd;
    always @(negedge mclk) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            check(reg_rdata & e[63:32], e[31:0]);
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        {mclk, rst, reg_wr, reg_rd, ctrl_suspended} = 5'h08;
        {reg_addr, reg_wdata, plug, fault} = '0;
        void'($urandom(87));
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(UPRC_OFS_ROUTE, UPRC_ROUTE_RESET, F);
        rd(UPRC_OFS_PORT1, UPRC_PORT_RESET, F);
        rd(8'h68, UPRC_PORT_RESET, F);
        rd(8'h6C, 32'h0000_0000, F);
        low(0);
        check(32'(companion_route), 32'h3);
        $display("reset values done");
        for (int p = 0; p < 2; p++) begin
            v = p == 0 ? 32'h0070_0000 : $urandom & 32'h0070_0000;
            pa = UPRC_OFS_PORT1 + 8'(4 * p);
            // Read-only and enable bits written as ones must not stick
            wr(pa, v | 32'h0000_0135);
            rd(pa, UPRC_PORT_RESET, M);
            wr(pa, 32'h0000_1000);
            // Power settle shortened from 20 ms to keep the run short
            low(20);
            wr(pa, v | 32'h0000_1135);
            rd(pa, v | 32'h0000_3000, M);
        end
        low(1);
        check(32'(port_power_on), 32'h3);
        $display("power and wake enables done");
        wr(UPRC_OFS_ROUTE, 32'h0000_0001);
        low(2);
        check(32'(companion_route), 32'h0);
        rd(UPRC_OFS_PORT1, 32'h0070_1000, M);
        wr(UPRC_OFS_PORT1, 32'h0070_3000);
        low(2);
        check(32'(companion_route), 32'h1);
        wr(UPRC_OFS_ROUTE, 32'h0000_0000);
        low(2);
        check(32'(companion_route), 32'h3);
        wr(UPRC_OFS_ROUTE, 32'h0000_0001);
        low(2);
        check(32'(companion_route), 32'h0);
        $display("routing done");
        wr(UPRC_OFS_IRQ_MASK, 32'h0000_007F);
        rd(UPRC_OFS_IRQ_MASK, 32'h0000_007F, F);
        ctrl_suspended <= 1'b1;
        plug[0] <= 1'b1;
        await_en(0);
        low(3);
        check(32'(wake_req), 32'h1);
        check(32'(irq), 32'h1);
        rd(UPRC_OFS_PORT1, 32'h0070_100F, M);
        rd(UPRC_OFS_IRQ_STAT, 32'h0000_0051, F);
        low(3);
        check(32'(irq), 32'h0);
        @(posedge mclk);
        ctrl_suspended <= 1'b0;
        low(3);
        check(32'(wake_req), 32'h0);
        plug[1] <= 1'b1;
        await_en(1);
        check(32'({port_enabled, wake_req}), 32'h6);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            ctrl_suspended <= 1'b1;
            @(posedge mclk);
            plug[0] <= k == 1;
            fault[0] <= k == 1;
            low(12);
            check(32'(wake_req), 32'h1);
            @(posedge mclk);
            ctrl_suspended <= 1'b0;
            low(3);
            check(32'(wake_req), 32'h0);
        end
        fault[0] <= 1'b0;
        plug[0] <= 1'b0;
        low(20);
        $display("events and wake done");
        @(posedge mclk);
        rst <= 1'b1;
        low(3);
        @(posedge mclk);
        rst <= 1'b0;
        rd(UPRC_OFS_PORT1, UPRC_PORT_RESET, M);
        rd(UPRC_OFS_ROUTE, UPRC_ROUTE_RESET, F);
        low(2);
        check(32'(companion_route), 32'h3);
        $display("second reset done");
        close_out();
    end
endmodule
`default_nettype wire
